// File: common/ecp_port_params.svh
// Constants for the extended capabilities parallel port core.
// Assumes an 8-bit ISA data path and a 10-bit configured base address.
// How it works
// R01: One shared 16-byte FIFO carries bytes in both directions.
// R02: Received run-length byte is dropped; following byte is repeated by count.
// R03: No negotiation; automatic DMA burst channel both ways in ECP mode.
// R04: Compatibility FIFO mode strobes each byte to the printer automatically.
// R05: Without extended mode the port acts as a standard printer port.
// R06: Host puts byte out, asserts strobe, interlocked with peripheral busy.
// R07: Peripheral drops busy when it can take another byte.
// R08: In reverse, peripheral busy level marks command versus data.
// R09: In reverse, peripheral asserts ack for valid data, interlocked with autofeed.
// R10: In reverse, host asserts autofeed to request each byte.
// R11: In forward, host autofeed level marks command versus data.
// R12: Init low turns the channel to reverse, high keeps it forward.
// R13: Peripheral answers reverse request by pulling paper error low.
// R14: Host drives the data bus only after paper error shows forward.
// R15: Peripheral drives data only in ECP, autofeed low, select-in high.
// R16: Select-in stays deasserted throughout ECP operation.
// R17: Peripheral may pull fault low as a hint; host alone picks direction.
// R18: Falling fault input can raise an error interrupt.
// R19: Three-bit mode field selects standard through configuration operation.
// R20: Decoded register set depends on mode; other modes undefined.
// R21: Extended registers sit at +400h, +401h, +402h via upper address bit.
// R22: Offsets add to base address; decode only while AEN is inactive.
// R23: Port word is fixed at eight bits.
// R24: Extended control bits 7 to 5 hold the read-write mode field.
// R25: ECP write at offset zero enters FIFO as command, sent with command flag.
// R26: Command bit 7 low gives run-length count, high gives channel address.
// R27: Run-length count N delivers the next data byte N plus one times.
`ifndef ECP_PORT_PARAMS_SVH
`define ECP_PORT_PARAMS_SVH
`define OFS_DATA 11'h000
`define OFS_DSR 11'h001
`define OFS_DCR 11'h002
`define OFS_FIFO 11'h400
`define OFS_CFGB 11'h401
`define OFS_ECR 11'h402
`define MODE_STD 3'h0
`define MODE_BIDIR 3'h1
`define MODE_COMPAT 3'h2
`define MODE_ECP 3'h3
`define MODE_EPP 3'h4
`define MODE_TEST 3'h6
`define MODE_CFG 3'h7
`define FIFO_DEPTH 5'h10
`define CFGA_VALUE 8'h10
`define CFGB_IRQ 3'h0
`define CFGB_DMA 3'h0
`define WR_THRESH 5'h08
`define RD_THRESH 5'h08
`define DCR_RESET 6'h00
`define DATA_RESET 8'h00
`define ECR_MODE_RESET 3'h0
`endif

// File: common/ecp_port_pkg.sv
// Types for the extended capabilities parallel port core.
// Assumes the constants header is included by users alongside.
package ecp_port_pkg;
	typedef enum logic [3:0] {F_IDLE = 4'h1, F_SETUP = 4'h2, F_STROBE = 4'h4,
		F_HOLD = 4'h8} fwd_state_t;
	typedef enum logic [3:0] {R_IDLE = 4'h1, R_REQ = 4'h2, R_ACK = 4'h4,
		R_REP = 4'h8} rev_state_t;
endpackage : ecp_port_pkg

// File: core/ecp_parallel_port.sv
// ISA-side extended capabilities parallel port with shared FIFO and decompression.
// Assumes ISA strobes are synchronous to mclk and a configured base address.
`timescale 1ns/1ps
`include "ecp_port_params.svh"
module ecp_parallel_port (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [10:0] sa,
	input wire logic [9:0] base_addr,
	input wire logic aen,
	input wire logic iow_b,
	input wire logic ior_b,
	input wire logic [7:0] sd_in,
	output logic [7:0] sd_out,
	output logic sd_oe_b,
	input wire logic dack_b,
	input wire logic tc,
	output logic drq,
	input wire logic irq_value,
	output logic irq_err,
	input wire logic [7:0] pd_in,
	output logic [7:0] pd_out,
	output logic pd_oe_b,
	output logic strobe_b,
	output logic autofd_b,
	output logic init_b,
	output logic selectin_b,
	input wire logic busy,
	input wire logic ack_b,
	input wire logic perror,
	input wire logic select,
	input wire logic fault_b
);
	//----------------------------------------
	// Registers and decode
	//----------------------------------------
	logic [8:0] mem [0:15];
	logic [3:0] wp_reg, rp_reg;
	logic [4:0] cnt_reg;
	logic [2:0] mode_reg;
	logic nerr_reg, dma_reg, serv_reg;
	logic [5:0] dcr_reg;
	logic [7:0] data_reg, out_reg, rev_byte_reg, sd_reg;
	logic tag_reg, iow_q, ior_q, fault_q, irq_reg, rle_pend_reg, have_reg;
	logic [6:0] rle_cnt_reg, rep_cnt_reg;
	ecp_port_pkg::fwd_state_t fst_reg;
	ecp_port_pkg::rev_state_t rst_reg;
	logic [10:0] rel;
	logic wr_stb, rd_stb, isa_sel, dma_acc, full, empty, ecp, fifo_mode, test, dir;
	logic hit_data, hit_dsr, hit_dcr, hit_fifo, hit_cfgb, hit_ecr, fifo_port;
	logic host_push, host_pop, rev_push, fwd_pop, push, pop, flush, serv_set, drive;
	logic [8:0] push_word;

	// Address relative to base, qualified by AEN
	assign rel = sa - {1'b0, base_addr}; // R22
	assign isa_sel = !aen && dack_b; // R22
	assign dma_acc = !dack_b;
	assign wr_stb = !iow_b && iow_q;
	assign rd_stb = !ior_b && ior_q;
	assign hit_data = isa_sel && (rel == `OFS_DATA);
	assign hit_dsr = isa_sel && (rel == `OFS_DSR);
	assign hit_dcr = isa_sel && (rel == `OFS_DCR);
	assign hit_fifo = isa_sel && (rel == `OFS_FIFO); // R21
	assign hit_cfgb = isa_sel && (rel == `OFS_CFGB); // R21
	assign hit_ecr = isa_sel && (rel == `OFS_ECR); // R21
	// Mode dependent views
	assign ecp = (mode_reg == `MODE_ECP); // R19
	assign test = (mode_reg == `MODE_TEST);
	assign fifo_mode = (mode_reg == `MODE_COMPAT) || ecp; // R20
	assign dir = dcr_reg[5] && (mode_reg != `MODE_STD) && (mode_reg != `MODE_COMPAT);
	assign fifo_port = (hit_fifo || dma_acc) && (fifo_mode || test); // R20
	assign full = (cnt_reg == `FIFO_DEPTH); // R01
	assign empty = (cnt_reg == 5'h00);

	//----------------------------------------
	// FIFO push and pop
	//----------------------------------------
	// Host side feeds forward bytes or command bytes
	assign host_push = wr_stb && !full && (test || !dir)
		&& (fifo_port || (hit_data && ecp)); // R25
	assign host_pop = rd_stb && fifo_port && !empty && (test || (ecp && dir));
	assign push = host_push || rev_push;
	assign pop = host_pop || fwd_pop;
	assign push_word = host_push ? {hit_data && ecp, sd_in} : {1'b0, rev_byte_reg}; // R25
	assign flush = wr_stb && hit_ecr && (sd_in[7:5] < `MODE_COMPAT);

	// Storage array
	always_ff @(posedge mclk)
	begin
		if (push)
			mem[wp_reg] <= push_word; // R01
	end

	// Pointers and fill count
	always_ff @(posedge mclk)
	begin
		if (!rst_b || flush)
		begin
			wp_reg <= 4'h0;
			rp_reg <= 4'h0;
			cnt_reg <= 5'h00;
		end
		else
		begin
			if (push)
				wp_reg <= wp_reg + 4'h1;
			if (pop)
				rp_reg <= rp_reg + 4'h1;
			if (push && !pop)
				cnt_reg <= cnt_reg + 5'h01; // R01
			else if (pop && !push)
				cnt_reg <= cnt_reg - 5'h01;
		end
	end

	//----------------------------------------
	// Host register writes
	//----------------------------------------
	// Strobe and fault history
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			iow_q <= 1'b1;
			ior_q <= 1'b1;
			fault_q <= 1'b1;
		end
		else
		begin
			iow_q <= iow_b;
			ior_q <= ior_b;
			fault_q <= fault_b;
		end
	end

	// Data, control and extended control
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			data_reg <= `DATA_RESET;
			dcr_reg <= `DCR_RESET;
			mode_reg <= `ECR_MODE_RESET;
			nerr_reg <= 1'b1;
			dma_reg <= 1'b0;
		end
		else if (wr_stb)
		begin
			if (hit_data && (mode_reg < `MODE_COMPAT))
				data_reg <= sd_in; // R05
			if (hit_dcr)
				dcr_reg <= sd_in[5:0];
			if (hit_ecr)
			begin
				mode_reg <= sd_in[7:5]; // R24
				nerr_reg <= sd_in[4];
				dma_reg <= sd_in[3];
			end
		end
	end

	// Service request: hardware set wins over software clear
	assign serv_set = !serv_reg && fifo_mode && (dma_reg ? (dma_acc && tc && (wr_stb || rd_stb))
		: (dir ? (cnt_reg >= `RD_THRESH) : ((`FIFO_DEPTH - cnt_reg) >= `WR_THRESH)));
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			serv_reg <= 1'b1;
		else if (serv_set)
			serv_reg <= 1'b1;
		else if (wr_stb && hit_ecr)
			serv_reg <= sd_in[2];
	end

	// Error interrupt on falling fault or on enabling while fault is low
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			irq_reg <= 1'b0;
		else
			irq_reg <= ecp && ((!nerr_reg && fault_q && !fault_b) // R18
				|| (wr_stb && hit_ecr && nerr_reg && !sd_in[4] && !fault_b)); // R17
	end
	assign irq_err = irq_reg;

	// DMA request in burst modes
	assign drq = dma_reg && !serv_reg && fifo_mode && (dir ? !empty : !full); // R03

	//----------------------------------------
	// Host register reads
	//----------------------------------------
	// Read data captured at the start of the read strobe
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
			sd_reg <= 8'h00;
		else if (rd_stb)
		begin
			if (hit_data)
				sd_reg <= pd_in; // R05
			else if (hit_dsr)
				sd_reg <= {~busy, ack_b, perror, select, fault_b, 3'h0};
			else if (hit_dcr)
				sd_reg <= {2'h0, dcr_reg};
			else if (hit_fifo && (mode_reg == `MODE_CFG))
				sd_reg <= `CFGA_VALUE; // R23
			else if (fifo_port)
				sd_reg <= empty ? mem[rp_reg - 4'h1][7:0] : mem[rp_reg][7:0];
			else if (hit_cfgb && (mode_reg == `MODE_CFG))
				sd_reg <= {1'b0, irq_value, `CFGB_IRQ, `CFGB_DMA};
			else if (hit_ecr)
				sd_reg <= {mode_reg, nerr_reg, dma_reg, serv_reg, full, empty}; // R24
			else
				sd_reg <= 8'hff;
		end
	end
	assign sd_out = sd_reg;
	assign sd_oe_b = !(!ior_b && (hit_data || hit_dsr || hit_dcr || hit_ecr || fifo_port
		|| ((hit_fifo || hit_cfgb) && (mode_reg == `MODE_CFG))));

	//----------------------------------------
	// Forward handshake engine
	//----------------------------------------
	assign fwd_pop = (fst_reg == ecp_port_pkg::F_IDLE) && !empty && !busy
		&& ((mode_reg == `MODE_COMPAT) || (ecp && !dir && perror)); // R14
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			fst_reg <= ecp_port_pkg::F_IDLE;
			out_reg <= 8'h00;
			tag_reg <= 1'b0;
		end
		else
		begin
			case (fst_reg)
				ecp_port_pkg::F_IDLE:
					if (fwd_pop)
					begin
						out_reg <= mem[rp_reg][7:0]; // R04
						tag_reg <= mem[rp_reg][8]; // R11
						fst_reg <= ecp_port_pkg::F_SETUP;
					end
				ecp_port_pkg::F_SETUP:
					fst_reg <= ecp_port_pkg::F_STROBE;
				ecp_port_pkg::F_STROBE:
					if (busy)
						fst_reg <= ecp_port_pkg::F_HOLD; // R06
				ecp_port_pkg::F_HOLD:
					if (!busy)
						fst_reg <= ecp_port_pkg::F_IDLE; // R07
				default:
					fst_reg <= ecp_port_pkg::F_IDLE;
			endcase
		end
	end

	//----------------------------------------
	// Reverse handshake and decompression
	//----------------------------------------
	assign rev_push = (rst_reg == ecp_port_pkg::R_REP) && !full; // R27
	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			rst_reg <= ecp_port_pkg::R_IDLE;
			rev_byte_reg <= 8'h00;
			rle_cnt_reg <= 7'h00;
			rep_cnt_reg <= 7'h00;
			rle_pend_reg <= 1'b0;
			have_reg <= 1'b0;
		end
		else
		begin
			case (rst_reg)
				ecp_port_pkg::R_IDLE:
					if (ecp && dir && !perror && !full)
						rst_reg <= ecp_port_pkg::R_REQ; // R14
				ecp_port_pkg::R_REQ:
					if (!ack_b) // R09
					begin
						rst_reg <= ecp_port_pkg::R_ACK;
						have_reg <= busy;
						if (busy) // R08
						begin
							rev_byte_reg <= pd_in;
							rep_cnt_reg <= rle_pend_reg ? rle_cnt_reg : 7'h00; // R27
							rle_pend_reg <= 1'b0;
						end
						else if (!pd_in[7]) // R26
						begin
							rle_cnt_reg <= pd_in[6:0]; // R02
							rle_pend_reg <= 1'b1;
						end
					end
				ecp_port_pkg::R_ACK:
					if (ack_b)
						rst_reg <= have_reg ? ecp_port_pkg::R_REP : ecp_port_pkg::R_IDLE;
				ecp_port_pkg::R_REP:
					if (!full)
					begin
						if (rep_cnt_reg == 7'h00)
							rst_reg <= ecp_port_pkg::R_IDLE;
						else
							rep_cnt_reg <= rep_cnt_reg - 7'h01; // R02
					end
				default:
					rst_reg <= ecp_port_pkg::R_IDLE;
			endcase
		end
	end

	//----------------------------------------
	// Parallel pins
	//----------------------------------------
	assign drive = ecp ? (!dir && perror) : !dir; // R14
	assign pd_oe_b = !drive;
	assign pd_out = fifo_mode ? out_reg : data_reg;
	assign strobe_b = fifo_mode ? (fst_reg != ecp_port_pkg::F_STROBE) : ~dcr_reg[0]; // R06
	assign autofd_b = ecp ? (dir ? (rst_reg != ecp_port_pkg::R_REQ) : !tag_reg)
		: ~dcr_reg[1]; // R10
	assign init_b = ecp ? !dir : dcr_reg[2]; // R12
	assign selectin_b = ecp ? 1'b1 : ~dcr_reg[3]; // R16

	//----------------------------------------
	// Checks
	//----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_fifo_bound: assert property (cnt_reg <= `FIFO_DEPTH) // R01
		else $error("fifo count above depth");
	a_select_high: assert property (ecp |-> selectin_b) // R16
		else $error("select-in asserted in ecp mode");
	a_no_clash: assert property ((ecp && !pd_oe_b) |-> (perror && init_b)) // R14
		else $error("data bus driven without forward acknowledge");
	a_strobe_wait: assert property ((fst_reg == ecp_port_pkg::F_STROBE && !busy && fifo_mode)
		|=> !strobe_b) // R06
		else $error("strobe released before busy");
	a_cmd_tag: assert property ((ecp && !dir && !strobe_b) |-> (autofd_b == !tag_reg) && $stable(pd_out)) // R11
		else $error("command flag wrong during strobe");
	a_rev_request: assert property ((ecp && dir && rst_reg == ecp_port_pkg::R_REQ && ack_b)
		|=> !autofd_b) // R10
		else $error("reverse request dropped early");
	a_rle_done: assert property ((rst_reg == ecp_port_pkg::R_REP && rep_cnt_reg == 7'h00 && !full
		&& !pop && !flush)
		|=> (rst_reg == ecp_port_pkg::R_IDLE && cnt_reg == $past(cnt_reg) + 5'h01)) // R27
		else $error("repeat did not end after last byte");
	a_err_irq: assert property ((ecp && !nerr_reg && fault_q && !fault_b) |=> irq_err) // R18
		else $error("fault edge gave no interrupt");
	a_init_dir: assert property ((ecp && dir) |-> !init_b) // R12
		else $error("reverse request not driven");
	c_fwd_byte: cover property (fst_reg == ecp_port_pkg::F_STROBE ##1 fst_reg == ecp_port_pkg::F_HOLD);
	c_rle_rep: cover property (rst_reg == ecp_port_pkg::R_REP && rep_cnt_reg > 7'h01);
	c_test_full: cover property (test && full);
endmodule : ecp_parallel_port

// File: testbench/ecp_peripheral_model.sv
// Behavioural peripheral on the far side of the parallel link.
// Assumes its inputs change just after the rising edge of mclk.
`timescale 1ns/1ps
module ecp_peripheral_model (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] pd_out,
	input wire logic strobe_b,
	input wire logic autofd_b,
	input wire logic init_b,
	input wire logic selectin_b,
	output logic [7:0] pd_in,
	output logic busy,
	output logic ack_b,
	output logic perror,
	output logic select
);
	logic [8:0] rx_q[$];
	logic [8:0] tx_q[$];
	int lag = 0;
	int cnt;
	assign select = 1'b1;
	// Forward capture, busy release and reverse sends
	always @(posedge mclk)
	begin
		if (!rst_b)
		begin
			busy <= 1'b0;
			ack_b <= 1'b1;
			perror <= 1'b1;
			pd_in <= 8'h00;
			cnt <= 0;
		end
		else
		begin
			perror <= init_b;
			if (!strobe_b && !busy)
			begin
				rx_q.push_back({autofd_b, pd_out});
				busy <= 1'b1;
				cnt <= 0;
			end
			else if (strobe_b && busy && ack_b)
			begin
				if (cnt >= lag)
					busy <= 1'b0;
				cnt <= cnt + 1;
			end
			if (!init_b && !perror && !autofd_b && selectin_b && ack_b && tx_q.size() > 0)
			begin
				pd_in <= tx_q[0][7:0];
				busy <= ~tx_q[0][8];
				ack_b <= 1'b0;
			end
			else if (autofd_b && !ack_b)
			begin
				ack_b <= 1'b1;
				void'(tx_q.pop_front());
			end
			else if (ack_b)
				pd_in <= ~pd_in; // Released bus keeps changing
		end
	end
endmodule : ecp_peripheral_model

// File: testbench/test_ecp_parallel_port.sv
// Self-checking bench for the parallel port core and its peripheral.
// Assumes the core's constants header is on the include path.
`timescale 1ns/1ps
`include "ecp_port_params.svh"
module test_ecp_parallel_port;
	logic mclk, rst_b, aen, iow_b, ior_b, fault_b, sd_oe_b, drq, irq_err, pd_oe_b;
	logic strobe_b, autofd_b, init_b, selectin_b, busy, ack_b, perror, select, dack_b, tc, oe;
	logic [10:0] sa;
	logic [7:0] sd_in, sd_out, pd_in, pd_out, v;
	logic [2:0] md[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
	logic [7:0] cd[3] = '{8'h81, 8'h00, 8'hff};
	int miscompares, n_checks, irq_n;
	localparam logic [9:0] base_a = 10'h278;
	ecp_parallel_port ecp_parallel_port_i (.mclk(mclk), .rst_b(rst_b), .sa(sa),
		.base_addr(base_a), .aen(aen), .iow_b(iow_b), .ior_b(ior_b), .sd_in(sd_in),
		.sd_out(sd_out), .sd_oe_b(sd_oe_b), .dack_b(dack_b), .tc(tc), .drq(drq),
		.irq_value(1'b1), .irq_err(irq_err), .pd_in(pd_in), .pd_out(pd_out),
		.pd_oe_b(pd_oe_b), .strobe_b(strobe_b), .autofd_b(autofd_b), .init_b(init_b),
		.selectin_b(selectin_b), .busy(busy), .ack_b(ack_b), .perror(perror),
		.select(select), .fault_b(fault_b));
	ecp_peripheral_model ecp_peripheral_model_i (.mclk(mclk), .rst_b(rst_b),
		.pd_out(pd_out), .strobe_b(strobe_b), .autofd_b(autofd_b), .init_b(init_b),
		.selectin_b(selectin_b), .pd_in(pd_in), .busy(busy), .ack_b(ack_b),
		.perror(perror), .select(select));
	// ----------------------------------------
	// Clock, pulse counter and helpers
	// ----------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	always @(posedge mclk)
		if (irq_err === 1'b1)
			irq_n++;
	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [10:0] o, input logic [7:0] d);
		sa = {1'b0, base_a} + o;
		sd_in = d;
		iow_b = 1'b0;
		@(posedge mclk);
		#1 iow_b = 1'b1;
		@(posedge mclk);
		#1;
	endtask : wr
	task automatic rd(input logic [10:0] o);
		sa = {1'b0, base_a} + o;
		ior_b = 1'b0;
		@(posedge mclk);
		@(posedge mclk);
		#1 v = sd_out;
		oe = sd_oe_b;
		ior_b = 1'b1;
		@(posedge mclk);
		#1;
	endtask : rd
	task automatic rc(input logic [10:0] o, input logic [7:0] e, input string nm);
		rd(o);
		chk(nm, {1'b0, e}, {1'b0, v});
	endtask : rc
	task automatic wt(input int n);
		int k;
		for (k = 0; k < 200 && ecp_peripheral_model_i.rx_q.size() < n; k++)
			@(posedge mclk);
		#1;
	endtask : wt
	task automatic finish_test;
		if (miscompares == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	initial
	begin
		#40000;
		miscompares++;
		finish_test();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		rst_b = 1'b0; aen = 1'b0; iow_b = 1'b1; ior_b = 1'b1;
		sa = 11'h000; sd_in = 8'h00; fault_b = 1'b1;
		dack_b = 1'b1;
		tc = 1'b0;
		repeat (10) @(posedge mclk);
		#1 rst_b = 1'b1;
		rc(`OFS_ECR, 8'h15, "ecr reset");
		chk("sd_oe_b mapped", 9'h000, {8'h0, oe});
		rc(`OFS_DCR, 8'h00, "dcr reset");
		wr(`OFS_DATA, 8'ha5);
		chk("pd_out", 9'h0a5, {1'b0, pd_out});
		aen = 1'b1;
		wr(`OFS_DATA, 8'h3c);
		aen = 1'b0;
		chk("pd_out aen", 9'h0a5, {1'b0, pd_out});
		rc(`OFS_DSR, 8'hd8, "dsr");
		wr(`OFS_DCR, 8'h0a);
		chk("ctl pins", 9'h008, {5'h0, strobe_b, autofd_b, selectin_b, init_b});
		rc(`OFS_FIFO, 8'hff, "unmapped");
		chk("sd_oe_b unmapped", 9'h001, {8'h0, oe});
		foreach (md[i])
		begin
			wr(`OFS_ECR, {md[i], 5'h04});
			rd(`OFS_ECR);
			chk("mode", {6'h0, md[i]}, {6'h0, v[7:5]});
		end
		rc(`OFS_FIFO, 8'h10, "config_a");
		rc(`OFS_CFGB, 8'h40, "config_b");
		// Fill test FIFO past full, then drain it
		wr(`OFS_ECR, 8'hc4);
		for (int i = 0; i < 17; i++)
			wr(`OFS_FIFO, 8'(8'h40 + i));
		rd(`OFS_ECR);
		chk("full", 9'h001, {8'h0, v[1]});
		for (int i = 0; i < 16; i++)
			rc(`OFS_FIFO, 8'(8'h40 + i), "fifo");
		rd(`OFS_ECR);
		chk("empty", 9'h001, {8'h0, v[0]});
		// Compatibility FIFO with a slow peripheral
		wr(`OFS_ECR, 8'h44);
		ecp_peripheral_model_i.lag = 3;
		ecp_peripheral_model_i.rx_q.delete();
		foreach (cd[i])
			wr(`OFS_FIFO, cd[i]);
		wt(3);
		foreach (cd[i])
			chk("compat", {1'b0, cd[i]}, {1'b0, ecp_peripheral_model_i.rx_q[i][7:0]});
		// ECP forward: command then data
		wr(`OFS_DCR, 8'h04);
		wr(`OFS_ECR, 8'h64);
		chk("selectin_b", 9'h001, {8'h0, selectin_b});
		ecp_peripheral_model_i.lag = 0;
		ecp_peripheral_model_i.rx_q.delete();
		wr(`OFS_DATA, 8'h82);
		wr(`OFS_FIFO, 8'h37);
		wt(2);
		chk("ecp cmd", 9'h082, ecp_peripheral_model_i.rx_q[0]);
		chk("ecp data", 9'h137, ecp_peripheral_model_i.rx_q[1]);
		// DMA burst: request while enabled, terminal count sets service
		wr(`OFS_ECR, 8'h68);
		chk("drq on", 9'h001, {8'h0, drq});
		aen = 1'b1;
		dack_b = 1'b0;
		tc = 1'b1;
		sd_in = 8'h5c;
		iow_b = 1'b0;
		@(posedge mclk);
		#1 iow_b = 1'b1;
		aen = 1'b0;
		dack_b = 1'b1;
		tc = 1'b0;
		@(posedge mclk);
		#1 chk("drq tc", 9'h000, {8'h0, drq});
		wt(3);
		chk("dma data", 9'h15c, ecp_peripheral_model_i.rx_q[2]);
		fault_b = 1'b0;
		repeat (6) @(posedge mclk);
		#1 chk("irq", 9'h001, 9'(irq_n));
		chk("dir kept", 9'h001, {8'h0, init_b});
		fault_b = 1'b1;
		// ECP reverse with a run-length count and a channel address
		ecp_peripheral_model_i.tx_q = '{9'h103, 9'h05a, 9'h185, 9'h011};
		wr(`OFS_DCR, 8'h20);
		chk("init_b rev", 9'h000, {8'h0, init_b});
		for (int k = 0; k < 300 && ecp_peripheral_model_i.tx_q.size() > 0; k++)
			@(posedge mclk);
		repeat (10) @(posedge mclk);
		#1 chk("pd_oe_b", 9'h001, {8'h0, pd_oe_b});
		for (int i = 0; i < 4; i++)
			rc(`OFS_FIFO, 8'h5a, "rle");
		rc(`OFS_FIFO, 8'h11, "rev data");
		rd(`OFS_ECR);
		chk("rev empty", 9'h001, {8'h0, v[0]});
		// Mid-run reset returns the port to standard mode
		rst_b = 1'b0;
		repeat (2) @(posedge mclk);
		#1 rst_b = 1'b1;
		chk("reset pins", 9'h00c, {5'h0, strobe_b, autofd_b, pd_oe_b, init_b});
		rc(`OFS_ECR, 8'h15, "ecr rerun");
		finish_test();
	end
endmodule : test_ecp_parallel_port
